/* design/encoder_sensor_register_map.sv */
// Register bank and thermal fault logic of the encoder sensor
// Functional notes
// - Shutdown trip: drivers and analog off, status bit 4 set.
// - Shutdown pulls fault pin low only when mask bit 0 is one.
// - Shutdown holds until interrupt register is read or reset.
// - Over alarm temperature sets status bit 5; pin low if mask bit 1.
// - Alarm only flags; drivers and consumers stay on.
// - Alarm bit and pin assertion hold until interrupt read or reset.
// - Index control bit 6 selects low-noise mode.
// - Pixel and column arrays are volatile, unreset, loaded by software.
// - Verify flag reads 0x0A after good loader sequence, else 0x00.
// - Register 0x088F is read-only lamp current code, reset 0x10.
// - Amp enables 0xFF, trip select 0xCC, loop control 0x26, lamp set 0x10, aux control 0x01, lamp readback 0x10, others zero.
// - Register 0x088B holds active-low buffer and comparator enables.
// - One lamp code step is nominally 0.6 mA.
// - Closed loop updates lamp current every 16 seconds.
module encoder_sensor_register_map
    import sensor_regs_pkg::*;
#(
    parameter int unsigned LOOP_PERIOD_CYCLES = LOOP_CYCLES
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // Register access from the serial-bus target
    input  wire logic [15:0] reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    // Power-up loader status
    input  wire logic        loader_busy_i,
    input  wire logic        loader_done_i,
    // Temperature comparators
    input  wire logic        over_shutdown_temp_i,
    input  wire logic        over_alarm_temp_i,
    // Fault pin and power controls
    output logic             fault_pin_n_o,
    output logic             drivers_enable_o,
    output logic             analog_enable_o,
    // Configuration to the analog path
    output logic             low_noise_o,
    output logic      [7:0]  amp_enable_o,
    output logic      [7:0]  buf_comp_enable_o,
    output logic      [7:0]  trip_select_o,
    output logic      [6:0]  lamp_code_o
);
    // Volatile arrays, deliberately without reset
    logic [7:0] pixel_mem   [PIXEL_DEPTH];
    logic [7:0] column_mem  [COLUMN_DEPTH];

    logic [7:0] trim_cos_q;
    logic [7:0] trim_sin_q;
    logic [7:0] mag_bal_q;
    logic [7:0] gain_trim_q;
    logic [7:0] quad_ctrl_q;
    logic [7:0] index_ctrl_q;
    logic [7:0] lamp_set_q;
    logic [7:0] lamp_loop_q;
    logic [7:0] trip_sel_q;
    logic [3:0] irq_mask_q;
    logic [7:0] amp_en_q;
    logic [7:0] buf_dis_q;
    logic [7:0] check_word_q;
    logic [7:0] aux_ctrl_q;
    logic [6:0] lamp_rb_q;
    logic       magic_seen_q;
    logic       verify_ok_q;
    logic       busy_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    logic       shdn_flag;
    logic       alarm_flag;
    logic       irq_read;
    logic       closed_loop;
    logic       loop_tick;
    logic [6:0] lamp_target;

    function automatic logic in_pixel(input logic [15:0] a);
        return a <= PIXEL_LAST;
    endfunction

    function automatic logic in_column(input logic [15:0] a);
        return (a >= COLUMN_BASE) && (a <= COLUMN_LAST);
    endfunction

    function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
        return a == o;
    endfunction

    // Array writes
    always_ff @(posedge ref_clk_i) begin
        if (reg_wr_i && in_pixel(reg_addr_i)) begin
            pixel_mem[reg_addr_i[8:0]] <= reg_wdata_i;
        end
        if (reg_wr_i && in_column(reg_addr_i)) begin
            column_mem[reg_addr_i[4:0]] <= reg_wdata_i;
        end
    end

    // Signal path trims
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            trim_cos_q  <= RST_ZERO;
            trim_sin_q  <= RST_ZERO;
            mag_bal_q   <= RST_ZERO;
            gain_trim_q <= RST_ZERO;
        end else if (reg_wr_i) begin
            // Unlisted offsets fall through and are dropped
            case (reg_addr_i)
                OFS_TRIM_COS:  trim_cos_q  <= reg_wdata_i;
                OFS_TRIM_SIN:  trim_sin_q  <= reg_wdata_i;
                OFS_MAG_BAL:   mag_bal_q   <= reg_wdata_i;
                OFS_GAIN_TRIM: gain_trim_q <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // Output controls
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            quad_ctrl_q  <= RST_ZERO;
            index_ctrl_q <= RST_ZERO;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                OFS_QUAD_CTRL:  quad_ctrl_q  <= reg_wdata_i;
                OFS_INDEX_CTRL: index_ctrl_q <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // Lamp drive settings
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lamp_set_q  <= RST_LAMP_SET;
            lamp_loop_q <= RST_LAMP_LOOP;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                OFS_LAMP_SET:  lamp_set_q  <= reg_wdata_i;
                OFS_LAMP_LOOP: lamp_loop_q <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // Thermal trip and interrupt mask
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            trip_sel_q <= RST_TRIP_SEL;
            irq_mask_q <= RST_ZERO[3:0];
        end else if (reg_wr_i) begin
            // Status bits are owned by the flags, so only masks store
            case (reg_addr_i)
                OFS_TRIP_SEL: trip_sel_q <= reg_wdata_i;
                OFS_IRQ:      irq_mask_q <= reg_wdata_i[3:0];
                default: ;
            endcase
        end
    end

    // Enables, check word and auxiliary controls
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            amp_en_q     <= RST_AMP_EN;
            buf_dis_q    <= RST_ZERO;
            check_word_q <= RST_ZERO;
            aux_ctrl_q   <= RST_AUX_CTRL;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                OFS_AMP_EN:     amp_en_q     <= reg_wdata_i;
                OFS_BUF_DIS:    buf_dis_q    <= reg_wdata_i;
                OFS_CHECK_WORD: check_word_q <= reg_wdata_i;
                OFS_AUX_CTRL:   aux_ctrl_q   <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // Loader signature tracking, armed at the start of each loader run
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_q       <= 1'b0;
            magic_seen_q <= 1'b0;
            verify_ok_q  <= 1'b0;
        end else begin
            busy_q <= loader_busy_i;
            if (loader_busy_i && !busy_q) begin
                magic_seen_q <= 1'b0;
                verify_ok_q  <= 1'b0;
            end else if (loader_busy_i && reg_wr_i
                         && hit(reg_addr_i, OFS_CHECK_WORD)
                         && reg_wdata_i == CHECK_MAGIC) begin
                magic_seen_q <= 1'b1;
            end
            if (loader_done_i) begin
                verify_ok_q <= magic_seen_q;
            end
        end
    end

    // Thermal events; a read clears, a pending event still wins
    assign irq_read = reg_rd_i && hit(reg_addr_i, OFS_IRQ);

    sticky_flag u_shdn_flag (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .set_i     (over_shutdown_temp_i),
        .clear_i   (irq_read),
        .flag_o    (shdn_flag)
    );

    sticky_flag u_alarm_flag (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .set_i     (over_alarm_temp_i),
        .clear_i   (irq_read),
        .flag_o    (alarm_flag)
    );

    // Alarm never touches the power controls
    assign drivers_enable_o = !shdn_flag;
    assign analog_enable_o  = !shdn_flag;

    // Pin low while any unmasked fault is latched
    assign fault_pin_n_o =
        !((shdn_flag && irq_mask_q[IRQ_MASK_SHDN])
        || (alarm_flag && irq_mask_q[IRQ_MASK_ALARM]));

    // Lamp current code; each step is LAMP_STEP_UA of drive
    assign closed_loop = lamp_set_q[LAMP_CLOSED_SEL]
                      && !lamp_loop_q[LOOP_HOLD];
    assign lamp_target = lamp_set_q[6:0];

    period_tick #(
        .PERIOD (LOOP_PERIOD_CYCLES)
    ) u_loop_tick (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .enable_i  (closed_loop),
        .tick_o    (loop_tick)
    );

    // Without a photodiode error input the loop slews one LSB per update
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lamp_rb_q <= RST_LAMP_RB;
        end else if (!closed_loop) begin
            lamp_rb_q <= lamp_target;
        end else if (loop_tick) begin
            if (lamp_rb_q < lamp_target) begin
                lamp_rb_q <= lamp_rb_q + 7'h01;
            end else if (lamp_rb_q > lamp_target) begin
                lamp_rb_q <= lamp_rb_q - 7'h01;
            end
        end
    end

    // Read mux; status is shown as it stood before the clearing read
    always_comb begin
        rdata_d = 8'h00;
        if (in_pixel(reg_addr_i)) begin
            rdata_d = pixel_mem[reg_addr_i[8:0]];
        end else if (in_column(reg_addr_i)) begin
            rdata_d = column_mem[reg_addr_i[4:0]];
        end else begin
            case (reg_addr_i)
                OFS_TRIM_COS:   rdata_d = trim_cos_q;
                OFS_TRIM_SIN:   rdata_d = trim_sin_q;
                OFS_MAG_BAL:    rdata_d = mag_bal_q;
                OFS_GAIN_TRIM:  rdata_d = gain_trim_q;
                OFS_QUAD_CTRL:  rdata_d = quad_ctrl_q;
                OFS_INDEX_CTRL: rdata_d = index_ctrl_q;
                OFS_LAMP_SET:   rdata_d = lamp_set_q;
                OFS_LAMP_LOOP:  rdata_d = lamp_loop_q;
                OFS_TRIP_SEL:   rdata_d = trip_sel_q;
                OFS_IRQ: begin
                    rdata_d = {4'h0, irq_mask_q} & IRQ_MASK_BITS;
                    rdata_d[IRQ_ST_SHDN]  = shdn_flag;
                    rdata_d[IRQ_ST_ALARM] = alarm_flag;
                end
                OFS_AMP_EN:     rdata_d = amp_en_q;
                OFS_BUF_DIS:    rdata_d = buf_dis_q;
                OFS_CHECK_WORD: rdata_d = check_word_q;
                OFS_AUX_CTRL:   rdata_d = aux_ctrl_q;
                OFS_VERIFY:     rdata_d = verify_ok_q ? VERIFY_OK
                                                      : RST_ZERO;
                OFS_LAMP_RB:    rdata_d = {1'b0, lamp_rb_q};
                default:        rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_i) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o       = rdata_q;
    assign low_noise_o       = index_ctrl_q[INDEX_LOW_NOISE];
    assign amp_enable_o      = shdn_flag ? 8'h00 : amp_en_q;
    assign buf_comp_enable_o = ~buf_dis_q;
    assign trip_select_o     = trip_sel_q;
    assign lamp_code_o       = shdn_flag ? 7'h00 : lamp_rb_q;
endmodule

/* design/period_tick.sv */
// Free counter giving a one-cycle tick every PERIOD cycles while enabled
module period_tick #(
    parameter int unsigned PERIOD = 16
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // Control
    input  wire logic enable_i,
    output logic      tick_o
);
    localparam int W = (PERIOD > 1) ? $clog2(PERIOD) : 1;
    localparam logic [W-1:0] LAST = W'(PERIOD - 1);

    logic [W-1:0] count_q;

    // Restarts whenever disabled so the first update is a full period away
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_q <= '0;
        end else if (!enable_i || count_q == LAST) begin
            count_q <= '0;
        end else begin
            count_q <= count_q + W'(1);
        end
    end

    assign tick_o = enable_i && (count_q == LAST);
endmodule

/* design/sensor_regs_pkg.sv */
// Address map, reset values and timing constants of the sensor register bank
package sensor_regs_pkg;
    // Address ranges of the volatile arrays
    localparam logic [15:0] PIXEL_BASE        = 16'h0000;
    localparam logic [15:0] PIXEL_LAST        = 16'h01FF;
    localparam logic [15:0] COLUMN_BASE       = 16'h0400;
    localparam logic [15:0] COLUMN_LAST       = 16'h041F;
    localparam int          PIXEL_DEPTH       = 512;
    localparam int          COLUMN_DEPTH      = 32;

    // Byte register offsets
    localparam logic [15:0] OFS_TRIM_COS      = 16'h0880;
    localparam logic [15:0] OFS_TRIM_SIN      = 16'h0881;
    localparam logic [15:0] OFS_MAG_BAL       = 16'h0882;
    localparam logic [15:0] OFS_GAIN_TRIM     = 16'h0883;
    localparam logic [15:0] OFS_QUAD_CTRL     = 16'h0884;
    localparam logic [15:0] OFS_INDEX_CTRL    = 16'h0885;
    localparam logic [15:0] OFS_LAMP_SET      = 16'h0886;
    localparam logic [15:0] OFS_LAMP_LOOP     = 16'h0887;
    localparam logic [15:0] OFS_TRIP_SEL      = 16'h0888;
    localparam logic [15:0] OFS_IRQ           = 16'h0889;
    localparam logic [15:0] OFS_AMP_EN        = 16'h088A;
    localparam logic [15:0] OFS_BUF_DIS       = 16'h088B;
    localparam logic [15:0] OFS_CHECK_WORD    = 16'h088C;
    localparam logic [15:0] OFS_AUX_CTRL      = 16'h088D;
    localparam logic [15:0] OFS_VERIFY        = 16'h088E;
    localparam logic [15:0] OFS_LAMP_RB       = 16'h088F;

    // Reset values
    localparam logic [7:0]  RST_ZERO          = 8'h00;
    localparam logic [7:0]  RST_LAMP_SET      = 8'h10;
    localparam logic [7:0]  RST_LAMP_LOOP     = 8'h26;
    localparam logic [7:0]  RST_TRIP_SEL      = 8'hCC;
    localparam logic [7:0]  RST_AMP_EN        = 8'hFF;
    localparam logic [7:0]  RST_AUX_CTRL      = 8'h01;
    localparam logic [6:0]  RST_LAMP_RB       = 7'h10;

    // Field positions
    localparam int          IRQ_MASK_SHDN     = 0;
    localparam int          IRQ_MASK_ALARM    = 1;
    localparam int          IRQ_ST_SHDN       = 4;
    localparam int          IRQ_ST_ALARM      = 5;
    localparam int          INDEX_LOW_NOISE   = 6;
    localparam int          LAMP_CLOSED_SEL   = 7;
    localparam int          LOOP_HOLD         = 7;
    localparam logic [7:0]  IRQ_MASK_BITS     = 8'h0F;

    // Loader check values
    localparam logic [7:0]  CHECK_MAGIC       = 8'hAA;
    localparam logic [7:0]  VERIFY_OK         = 8'h0A;

    // Nominal drive step per code LSB, in microamps
    localparam int          LAMP_STEP_UA      = 600;

    // Closed-loop update period
    localparam int          CLK_HZ            = 20_000_000;
    localparam int          LOOP_PERIOD_S     = 16;
    localparam int unsigned LOOP_CYCLES       = LOOP_PERIOD_S * CLK_HZ;
endpackage

/* design/sticky_flag.sv */
// Sticky event flag: set wins over clear
module sticky_flag (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // Control
    input  wire logic set_i,
    input  wire logic clear_i,
    // State
    output logic      flag_o
);
    logic flag_q;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else if (set_i) begin
            flag_q <= 1'b1;
        end else if (clear_i) begin
            flag_q <= 1'b0;
        end
    end

    assign flag_o = flag_q;
endmodule

/* tb/encoder_sensor_register_map_assertions.sv */
// Port assertions of the sensor register bank
module encoder_sensor_register_map_assertions
    import sensor_regs_pkg::*;
(
    // Clock, reset and register port
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic [7:0]  reg_rdata_o,
    // Thermal inputs, fault and power outputs, and analog path configuration outputs
    input wire logic        over_shutdown_temp_i,
    input wire logic        over_alarm_temp_i,
    input wire logic        fault_pin_n_o,
    input wire logic        drivers_enable_o,
    input wire logic        analog_enable_o,
    input wire logic        low_noise_o,
    input wire logic [7:0]  amp_enable_o,
    input wire logic [7:0]  buf_comp_enable_o,
    input wire logic [6:0]  lamp_code_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic irq_rd;
    logic irq_wr;
    logic hole;
    assign irq_rd = reg_rd_i && reg_addr_i == OFS_IRQ;
    assign irq_wr = reg_wr_i && reg_addr_i == OFS_IRQ;
    // Gaps only; array contents are unknown and not judged here
    assign hole = (reg_addr_i > PIXEL_LAST && reg_addr_i < COLUMN_BASE)
        || (reg_addr_i > COLUMN_LAST && reg_addr_i < OFS_TRIM_COS)
        || reg_addr_i > OFS_LAMP_RB;
    property p_shdn_off;
        over_shutdown_temp_i |=> !drivers_enable_o && !analog_enable_o
            && amp_enable_o == 8'h00 && lamp_code_o == 7'h00;
    endproperty
    a_shdn_off: assert property (p_shdn_off) else $error("shutdown");
    property p_pin_cause;
        $fell(fault_pin_n_o) |->
            $past(over_shutdown_temp_i || over_alarm_temp_i || irq_wr);
    endproperty
    a_pin_cause: assert property (p_pin_cause) else $error("pin");
    property p_shdn_hold;
        !drivers_enable_o && !irq_rd |=> !drivers_enable_o;
    endproperty
    a_shdn_hold: assert property (p_shdn_hold) else $error("hold");
    property p_alarm_on;
        drivers_enable_o && !over_shutdown_temp_i |=>
            drivers_enable_o && analog_enable_o;
    endproperty
    a_alarm_on: assert property (p_alarm_on) else $error("alarm");
    property p_pin_hold;
        !fault_pin_n_o && !irq_rd && !irq_wr |=> !fault_pin_n_o;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("sticky");
    property p_release;
        irq_rd && !over_shutdown_temp_i && !over_alarm_temp_i |=>
            fault_pin_n_o && drivers_enable_o;
    endproperty
    a_release: assert property (p_release) else $error("release");
    property p_hole;
        reg_rd_i && hole |=> reg_rdata_o == 8'h00;
    endproperty
    a_hole: assert property (p_hole) else $error("unmapped");
    property p_low_noise;
        reg_wr_i && reg_addr_i == OFS_INDEX_CTRL |=>
            low_noise_o == $past(reg_wdata_i[INDEX_LOW_NOISE]);
    endproperty
    a_low_noise: assert property (p_low_noise) else $error("noise");
    property p_buf_en;
        reg_wr_i && reg_addr_i == OFS_BUF_DIS |=>
            buf_comp_enable_o == ~$past(reg_wdata_i);
    endproperty
    a_buf_en: assert property (p_buf_en) else $error("buffers");
endmodule

bind encoder_sensor_register_map encoder_sensor_register_map_assertions
    u_encoder_sensor_register_map_assertions (
    .ref_clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .over_shutdown_temp_i, .over_alarm_temp_i, .fault_pin_n_o,
    .drivers_enable_o, .analog_enable_o, .low_noise_o, .amp_enable_o,
    .buf_comp_enable_o, .lamp_code_o
);

/* tb/encoder_sensor_register_map_tb.sv */
// Self-checking bench of the sensor register bank
module encoder_sensor_register_map_tb
    import sensor_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // Short lamp period keeps the closed-loop test brief
    localparam int unsigned PER = 20;
    logic        ref_clk_i, rst_i, reg_wr_i, reg_rd_i, rd_d;
    logic        loader_busy_i, loader_done_i, fault_pin_n_o, low_noise_o;
    logic        over_shutdown_temp_i, over_alarm_temp_i;
    logic        drivers_enable_o, analog_enable_o;
    logic [15:0] reg_addr_i;
    logic [7:0]  reg_wdata_i, reg_rdata_o, amp_enable_o, buf_comp_enable_o;
    logic [7:0]  trip_select_o, exp_q [$];
    logic [6:0]  lamp_code_o;
    int          miscompares, n_compared, cycles;
    encoder_sensor_register_map #(
        .LOOP_PERIOD_CYCLES(PER)
    ) u_encoder_sensor_register_map (
        .ref_clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
        .reg_wdata_i, .reg_rdata_o, .loader_busy_i, .loader_done_i,
        .over_shutdown_temp_i, .over_alarm_temp_i, .fault_pin_n_o,
        .drivers_enable_o, .analog_enable_o, .low_noise_o, .amp_enable_o,
        .buf_comp_enable_o, .trip_select_o, .lamp_code_o
    );
    sensor_host_model u_sensor_host_model (
        .ref_clk_i, .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
        .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i),
        .loader_busy_o(loader_busy_i), .loader_done_o(loader_done_i)
    );
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        u_sensor_host_model.access(1'b1, a, d, 1 + $urandom_range(2));
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_sensor_host_model.access(1'b0, a, 8'h00, 1 + $urandom_range(2));
    endtask
    // Read data lands one edge after the strobe and holds until the next
    always @(posedge ref_clk_i) begin
        if (rd_d)
            check(reg_rdata_o, exp_q.pop_front());
        rd_d <= reg_rd_i;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic trip(input logic sd, input logic [7:0] m);
        logic pin;
        pin = sd ? !m[IRQ_MASK_SHDN] : !m[IRQ_MASK_ALARM];
        wr(OFS_IRQ, m);
        over_shutdown_temp_i = sd;
        over_alarm_temp_i = !sd;
        @(posedge ref_clk_i);
        #1;
        over_shutdown_temp_i = 1'b0;
        over_alarm_temp_i = 1'b0;
        repeat (2) begin
            check({7'h00, fault_pin_n_o}, {7'h00, pin});
            check({6'h00, drivers_enable_o, analog_enable_o},
                  {6'h00, !sd, !sd});
            check({1'b0, lamp_code_o} | (sd ? amp_enable_o : 8'h00),
                  sd ? 8'h00 : 8'h10);
            repeat (4) @(posedge ref_clk_i);
            #1;
        end
        rd(OFS_IRQ, {2'b00, !sd, sd, m[3:0]});
        check({6'h00, fault_pin_n_o, drivers_enable_o}, 8'h03);
    endtask
    initial begin
        logic [7:0]  v;
        logic [15:0] a;
        logic [15:0] ro_a [8];
        logic [15:0] arr_a [4];
        logic [7:0]  arr_v [4];
        logic [7:0]  rst_v [16];
        rst_i = 1'b1;
        rd_d = 1'b0;
        over_shutdown_temp_i = 1'b0;
        over_alarm_temp_i = 1'b0;
        v = 8'($urandom(32'h400F));
        rst_v = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h26,
                  8'hCC, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h01, 8'h00, 8'h10};
        ro_a = '{16'h088E, 16'h088F, 16'h0200, 16'h03FF,
                 16'h0420, 16'h087F, 16'h0890, 16'hFFFF};
        arr_a = '{PIXEL_BASE, PIXEL_LAST, COLUMN_BASE, COLUMN_LAST};
        repeat (10) @(posedge ref_clk_i);
        #1;
        rst_i = 1'b0;
        check(amp_enable_o, 8'hFF);
        check(trip_select_o, 8'hCC);
        check(buf_comp_enable_o, 8'hFF);
        check({1'b0, lamp_code_o}, 8'h10);
        for (int i = 0; i < 16; i++)
            rd(OFS_TRIM_COS + 16'(i), rst_v[i]);
        $display("reset values done");
        for (int i = 0; i < 14; i++) begin
            a = OFS_TRIM_COS + 16'(i);
            v = 8'($urandom);
            if (a == OFS_LAMP_SET || a == OFS_LAMP_LOOP)
                continue;
            wr(a, v);
            case (a)
                OFS_INDEX_CTRL:
                    check({7'h00, low_noise_o}, {7'h00, v[6]});
                OFS_AMP_EN: check(amp_enable_o, v);
                OFS_BUF_DIS: check(buf_comp_enable_o, ~v);
                OFS_TRIP_SEL: check(trip_select_o, v);
                default: ;
            endcase
            rd(a, a == OFS_IRQ ? {4'h0, v[3:0]} : v);
        end
        foreach (ro_a[i]) begin
            wr(ro_a[i], 8'($urandom));
            rd(ro_a[i], ro_a[i] == OFS_LAMP_RB ? 8'h10 : 8'h00);
        end
        foreach (arr_a[i]) begin
            arr_v[i] = 8'($urandom);
            wr(arr_a[i], arr_v[i]);
        end
        foreach (arr_a[i])
            rd(arr_a[i], arr_v[i]);
        $display("access kinds done");
        trip(1'b1, 8'h01);
        trip(1'b1, 8'h0E);
        trip(1'b0, 8'h02);
        trip(1'b0, 8'h0D);
        $display("thermal done");
        u_sensor_host_model.load(8'hAA);
        rd(OFS_VERIFY, 8'h0A);
        u_sensor_host_model.load(8'h55);
        rd(OFS_VERIFY, 8'h00);
        $display("loader done");
        wr(OFS_LAMP_SET, 8'h05);
        rd(OFS_LAMP_RB, 8'h05);
        wr(OFS_LAMP_SET, 8'h88);
        rd(OFS_LAMP_RB, 8'h05);
        repeat (3 * PER + 4) @(posedge ref_clk_i);
        rd(OFS_LAMP_RB, 8'h08);
        check({1'b0, lamp_code_o}, 8'h08);
        $display("lamp loop done");
        repeat (2) @(posedge ref_clk_i);
        finish_test();
    end
endmodule

/* tb/sensor_host_model.sv */
// Serial-bus controller and power-up loader model on the register port
module sensor_host_model
    import sensor_regs_pkg::*;
(
    // Clock
    input  wire logic        ref_clk_i,
    // Register port
    output logic      [15:0] reg_addr_o,
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    output logic      [7:0]  reg_wdata_o,
    // Loader status
    output logic             loader_busy_o,
    output logic             loader_done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_addr_o = 16'h0000;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 8'h00;
        loader_busy_o = 1'b0;
        loader_done_o = 1'b0;
    end
    // Gap of at least one edge, so no strobe is set twice in a time step
    task automatic access(input logic wr, input logic [15:0] a,
                          input logic [7:0] d, input int gap);
        repeat (gap) @(posedge ref_clk_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = wr;
        reg_rd_o = !wr;
        @(posedge ref_clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        // Released lines flip so a stale value is never reused
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask
    task automatic load(input logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        loader_busy_o = 1'b1;
        access(1'b1, OFS_CHECK_WORD, d, 1);
        loader_done_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        loader_done_o = 1'b0;
        loader_busy_o = 1'b0;
    endtask
endmodule
